// ### core/riser_usb_lan_config_loader.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "loader_params.svh"
module riser_usb_lan_config_loader
(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // smbus pins
    input  wire logic          scl_i,
    output logic               scl_o,
    output logic               scl_oe,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    // operator and status
    input  wire logic          err_ack,
    output logic               irq,
    output logic               mac_disable,
    output logic               lan_disable,
    output logic               usb_opt_valid,
    output logic [15:0]        usb_opt_word,
    // pci configuration writes
    output logic               cfg_wr_valid,
    output loader_pkg::id_sel_t cfg_wr_sel,
    output logic [15:0]        cfg_wr_data,
    input  wire logic          cfg_wr_ready
);
    import loader_pkg::*;

    loader_state_t r;
    loader_state_t next_r;

    always_comb
    begin
        logic        tick;
        logic        adv;
        logic        bit8;
        logic        wr_frame;
        logic        byte_done;
        logic        word_rdy;
        logic        go_end;
        logic        last;
        logic        wr;
        logic        setup;
        logic        hit;
        logic        start_wr;
        logic        ack;
        logic [7:0]  rd_byte;
        logic [15:0] w;
        logic [15:0] len;
        logic [31:0] rdat;
        irq_vec_t    set;
        irq_vec_t    clr;
        irq_vec_t    body_err;
        next_r    = r;
        tick      = (r.qcnt == `QCNT_MAX);
        adv       = 1'b0;
        bit8      = (r.bitn == 4'h8);
        wr_frame  = (r.frame != 2'h3);
        byte_done = 1'b0;
        word_rdy  = 1'b0;
        go_end    = 1'b0;
        last      = 1'b0;
        wr        = psel & penable & pwrite;
        setup     = psel & ~penable;
        hit       = 1'b1;
        start_wr  = 1'b0;
        ack       = err_ack;
        rd_byte   = r.nack ? 8'hff : r.sh;
        w         = 16'h0000;
        len       = 16'h0000;
        rdat      = 32'h0000_0000;
        set       = '0;
        clr       = '0;
        body_err  = '0;

        // pin synchronisers, a change counts once stages two and three agree
        next_r.scl_s1 = scl_i;
        next_r.scl_s2 = r.scl_s1;
        next_r.scl_s3 = r.scl_s2;
        next_r.sda_s1 = sda_i;
        next_r.sda_s2 = r.sda_s1;
        next_r.sda_s3 = r.sda_s2;
        if (r.scl_s2 == r.scl_s3)
            next_r.scl_f = r.scl_s3;
        if (r.sda_s2 == r.sda_s3)
            next_r.sda_f = r.sda_s3;

        // apb register access
        if (wr)
        begin
            case (paddr)
                `REG_CTRL:
                begin
                    start_wr      = pwdata[`CTRL_START] && (r.ms == M_IDLE);
                    next_r.cfg_en = pwdata[`CTRL_CFG_EN];
                    ack           = err_ack | pwdata[`CTRL_ACK];
                end
                `REG_HOST:
                begin
                    next_r.host_iface = pwdata[`HOST_IFACE_BIT];
                    next_r.host_spd   = pwdata[`HOST_SPD_LSB +: 2];
                end
                `REG_HOST_USB: next_r.host_usb_lvl = pwdata[15:0];
                `REG_HOST_LAN: next_r.host_lan_ver = pwdata[15:0];
                `REG_IRQ_CLR:  clr = pwdata[`IRQ_W-1:0];
                `REG_IRQ_EN:   next_r.irq_en = pwdata[`IRQ_W-1:0];
                default: ;
            endcase
        end
        case (paddr)
            `REG_CTRL:     rdat = {30'h0000_0000, r.cfg_en, 1'b0};
            `REG_HOST:     rdat = {29'h0000_0000, r.host_spd, r.host_iface};
            `REG_HOST_USB: rdat = {16'h0000, r.host_usb_lvl};
            `REG_HOST_LAN: rdat = {16'h0000, r.host_lan_ver};
            `REG_STATUS:   rdat = {24'h00_0000, r.ms, r.usb_opt_valid, r.lan_dis, r.mac_dis, (r.ms != M_IDLE)};
            `REG_IRQ_STAT: rdat = {23'h00_0000, r.irq_stat};
            `REG_IRQ_CLR:  rdat = 32'h0000_0000;
            `REG_IRQ_EN:   rdat = {23'h00_0000, r.irq_en};
            `REG_USB_OPT:  rdat = {14'h0000, r.usb_spd, r.usb_opt};
            `REG_USB_LVL:  rdat = {16'h0000, r.usb_lvl};
            `REG_LAN_IDS:  rdat = {r.lan_sid, r.lan_svid};
            `REG_LAN_VER:  rdat = {16'h0000, r.lan_ver};
            default:       hit  = 1'b0;
        endcase
        next_r.prdata  = setup ? rdat : r.prdata;
        next_r.pslverr = setup & ~hit;

        adv = tick && !(r.qtr == 2'h2 && !r.scl_f);
        if (r.bs == B_IDLE)
            next_r.qcnt = 10'h000;
        else if (!adv)
        begin
            if (!tick)
                next_r.qcnt = r.qcnt + 10'h001;
        end
        else
        begin
            next_r.qcnt = 10'h000;
            next_r.qtr  = r.qtr + 2'h1;
            case (r.qtr)
                2'h0:
                begin
                    case (r.bs)
                        B_START: next_r.sda_oe = 1'b0;
                        B_STOP:  next_r.sda_oe = 1'b1;
                        B_BIT:   next_r.sda_oe = bit8 ? 1'b0 : (wr_frame & ~r.sh[7]);
                        default: ;
                    endcase
                end
                2'h1: next_r.scl_oe = 1'b0;
                2'h2:
                begin
                    case (r.bs)
                        B_START: next_r.sda_oe = 1'b1;
                        B_STOP:  next_r.sda_oe = 1'b0;
                        B_BIT:
                        begin
                            if (bit8)
                            begin
                                if (wr_frame && r.sda_f)
                                begin
                                    next_r.nack     = 1'b1;
                                    set[`IRQ_NACK]  = 1'b1;
                                end
                            end
                            else if (!wr_frame)
                                next_r.sh = {r.sh[6:0], r.sda_f};
                        end
                        default: ;
                    endcase
                end
                default:
                begin
                    case (r.bs)
                        B_START:
                        begin
                            next_r.scl_oe = 1'b1;
                            next_r.bs     = B_BIT;
                            next_r.bitn   = 4'h0;
                            next_r.sh     = {`EE_DEV_ADDR, (r.frame == 2'h2)};
                        end
                        B_STOP:
                        begin
                            next_r.bs = B_IDLE;
                            byte_done = 1'b1;
                        end
                        B_BIT:
                        begin
                            next_r.scl_oe = 1'b1;
                            if (!bit8)
                            begin
                                next_r.bitn = r.bitn + 4'h1;
                                if (wr_frame)
                                    next_r.sh = {r.sh[6:0], 1'b0};
                            end
                            else
                            begin
                                next_r.bitn = 4'h0;
                                if (r.nack || r.frame == 2'h3)
                                    next_r.bs = B_STOP;
                                else if (r.frame == 2'h1)
                                begin
                                    next_r.bs    = B_START;
                                    next_r.frame = 2'h2;
                                end
                                else
                                begin
                                    next_r.frame = r.frame + 2'h1;
                                    next_r.sh    = r.rd_addr;
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            endcase
        end

        // record walk
        case (r.ms)
            M_IDLE:
            begin
                if (start_wr)
                begin
                    next_r.addr          = `USB_PTR_ADDR;
                    next_r.rec           = 1'b0;
                    next_r.hi            = 1'b0;
                    next_r.req           = 1'b0;
                    next_r.skip          = 1'b0;
                    next_r.mac_dis       = 1'b0;
                    next_r.lan_dis       = 1'b0;
                    next_r.usb_opt_valid = 1'b0;
                    next_r.ms            = M_PTR;
                end
            end
            M_PTR, M_SCAN, M_BODY:
            begin
                if (!r.req)
                begin
                    next_r.req     = 1'b1;
                    next_r.bs      = B_START;
                    next_r.frame   = 2'h0;
                    next_r.qtr     = 2'h0;
                    next_r.nack    = 1'b0;
                    next_r.rd_addr = r.addr + {7'h00, r.hi};
                end
                else if (byte_done)
                begin
                    next_r.req = 1'b0;
                    next_r.hi  = ~r.hi;
                    if (!r.hi)
                        next_r.word_lo = rd_byte;
                    else
                    begin
                        // second byte read is the upper byte
                        w           = {rd_byte, r.word_lo};
                        word_rdy    = 1'b1;
                        next_r.addr = r.addr + `PTR_STEP;
                    end
                end
            end
            M_ACK:
            begin
                if (ack)
                begin
                    next_r.ms = M_BODY;
                    go_end    = r.skip;
                end
            end
            M_CFG:
            begin
                if (cfg_wr_ready)
                begin
                    if (r.cfg_sel == SEL_SVID)
                        next_r.cfg_sel = SEL_SID;
                    else
                    begin
                        next_r.cfg_valid = 1'b0;
                        next_r.ms        = M_DONE;
                    end
                end
            end
            M_DONE:
            begin
                set[`IRQ_DONE] = 1'b1;
                next_r.ms      = M_IDLE;
            end
            default: next_r.ms = M_IDLE;
        endcase

        if (word_rdy)
        begin
            case (r.ms)
                M_PTR:
                begin
                    next_r.rec_ptr = w;
                    next_r.ms      = M_SCAN;
                end
                M_SCAN:
                begin
                    if (w != 16'h0000 || r.addr == `PTR_LAST_ADDR)
                    begin
                        len         = w - r.rec_ptr;
                        next_r.addr = r.rec_ptr[7:0];
                        next_r.widx = 2'h0;
                        next_r.ms   = M_BODY;
                        if (!r.rec && len != `USB_REC_LEN)
                            set[`IRQ_USB_LEN] = 1'b1;
                        if (r.rec && len != `LAN_REC_LEN)
                            set[`IRQ_LAN_LEN] = 1'b1;
                        if (set[`IRQ_USB_LEN] || set[`IRQ_LAN_LEN])
                        begin
                            next_r.skip = 1'b1;
                            next_r.ms   = M_ACK;
                        end
                    end
                end
                M_BODY:
                begin
                    next_r.widx = r.widx + 2'h1;
                    last = (r.widx == (r.rec ? `LAN_LAST_WORD : `USB_LAST_WORD));
                    if (!r.rec)
                    begin
                        case (r.widx)
                            2'h0:
                            begin
                                next_r.usb_opt = {w[15:2], 2'b00};
                                next_r.usb_spd = w[`USB_SPD_LSB +: 2];
                            end
                            2'h1:
                            begin
                                next_r.usb_lvl = w;
                                body_err[`IRQ_USB_COMPL] = (w > r.host_usb_lvl);
                                next_r.usb_opt_valid = 1'b1;
                                body_err[`IRQ_USB_SLOW] = (r.usb_spd > r.host_spd);
                                body_err[`IRQ_USB_DISC] = (r.usb_spd < r.host_spd);
                            end
                            default: ;
                        endcase
                    end
                    else
                    begin
                        case (r.widx)
                            2'h0:
                            begin
                                if (w[`LAN_IFACE_BIT] != r.host_iface)
                                begin
                                    next_r.mac_dis            = 1'b1;
                                    body_err[`IRQ_LAN_IFACE]  = 1'b1;
                                end
                            end
                            2'h1: next_r.lan_svid = w;
                            2'h2: next_r.lan_sid = w;
                            default:
                            begin
                                next_r.lan_ver = w;
                                if (w > r.host_lan_ver)
                                begin
                                    next_r.lan_dis         = 1'b1;
                                    body_err[`IRQ_LAN_VER] = 1'b1;
                                end
                            end
                        endcase
                    end
                    set = set | body_err;
                    if (body_err != '0)
                    begin
                        next_r.skip = last;
                        next_r.ms   = M_ACK;
                    end
                    else
                        go_end = last;
                end
                default: ;
            endcase
        end

        if (go_end)
        begin
            next_r.skip = 1'b0;
            if (!r.rec)
            begin
                next_r.rec  = 1'b1;
                next_r.addr = `LAN_PTR_ADDR;
                next_r.ms   = M_PTR;
            end
            else if (r.cfg_en && !r.skip && !next_r.mac_dis && !next_r.lan_dis)
            begin
                next_r.cfg_valid = 1'b1;
                next_r.cfg_sel   = SEL_SVID;
                next_r.ms        = M_CFG;
            end
            else
                next_r.ms = M_DONE;
        end

        // sticky flags, set wins over clear
        next_r.irq_stat = (r.irq_stat & ~clr) | set;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign prdata        = r.prdata;
    assign pready        = 1'b1;
    assign pslverr       = r.pslverr;
    assign scl_o         = 1'b0;
    assign scl_oe        = r.scl_oe;
    assign sda_o         = 1'b0;
    assign sda_oe        = r.sda_oe;
    assign irq           = |(r.irq_stat & r.irq_en);
    assign mac_disable   = r.mac_dis;
    assign lan_disable   = r.lan_dis;
    assign usb_opt_valid = r.usb_opt_valid;
    assign usb_opt_word  = r.usb_opt;
    assign cfg_wr_valid  = r.cfg_valid;
    assign cfg_wr_sel    = r.cfg_sel;
    assign cfg_wr_data   = (r.cfg_sel == SEL_SID) ? r.lan_sid : r.lan_svid;
endmodule : riser_usb_lan_config_loader
`default_nettype wire

// ### core/loader_params.svh
`ifndef LOADER_PARAMS_SVH
`define LOADER_PARAMS_SVH
// eeprom map and record layout
`define EE_DEV_ADDR     7'h57
`define USB_PTR_ADDR    8'h12
`define LAN_PTR_ADDR    8'h16
`define PTR_LAST_ADDR   8'h2e
`define PTR_STEP        8'h02
`define USB_REC_LEN     16'h0006
`define LAN_REC_LEN     16'h0008
`define USB_LAST_WORD   2'h2
`define LAN_LAST_WORD   2'h3
`define LAN_IFACE_BIT   0
`define USB_SPD_LSB     0
// smbus quarter-bit timing, least time rounds up
`define CLK_MHZ         200
`define SMB_QTR_NS      2500
`define SMB_QTR_CYC     ((`SMB_QTR_NS * `CLK_MHZ + 999) / 1000)
`define QCNT_MAX        10'((`SMB_QTR_CYC) - 1)
// apb register offsets
`define REG_CTRL        8'h00
`define REG_HOST        8'h04
`define REG_HOST_USB    8'h08
`define REG_HOST_LAN    8'h0c
`define REG_STATUS      8'h10
`define REG_IRQ_STAT    8'h14
`define REG_IRQ_CLR     8'h18
`define REG_IRQ_EN      8'h1c
`define REG_USB_OPT     8'h20
`define REG_USB_LVL     8'h24
`define REG_LAN_IDS     8'h28
`define REG_LAN_VER     8'h2c
// control and host fields
`define CTRL_START      0
`define CTRL_CFG_EN     1
`define CTRL_ACK        2
`define HOST_IFACE_BIT  0
`define HOST_SPD_LSB    1
// event bits
`define IRQ_DONE        0
`define IRQ_USB_LEN     1
`define IRQ_USB_COMPL   2
`define IRQ_USB_SLOW    3
`define IRQ_USB_DISC    4
`define IRQ_LAN_LEN     5
`define IRQ_LAN_IFACE   6
`define IRQ_LAN_VER     7
`define IRQ_NACK        8
`define IRQ_W           9
`endif

// ### core/loader_pkg.sv
`include "loader_params.svh"
package loader_pkg;
    typedef enum logic [3:0] {
        M_IDLE = 4'h0, M_PTR = 4'h1, M_SCAN = 4'h2, M_BODY = 4'h3,
        M_ACK = 4'h4, M_CFG = 4'h5, M_DONE = 4'h6
    } main_state_t;
    typedef enum logic [1:0] {
        B_IDLE = 2'h0, B_START = 2'h1, B_BIT = 2'h2, B_STOP = 2'h3
    } bus_state_t;
    typedef enum logic {SEL_SVID = 1'b0, SEL_SID = 1'b1} id_sel_t;
    typedef logic [`IRQ_W-1:0] irq_vec_t;
    typedef struct packed {
        main_state_t ms;
        bus_state_t  bs;
        logic [1:0]  qtr;
        logic [9:0]  qcnt;
        logic [1:0]  frame;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        nack;
        logic        scl_oe;
        logic        sda_oe;
        logic        scl_s1, scl_s2, scl_s3, scl_f;
        logic        sda_s1, sda_s2, sda_s3, sda_f;
        logic        req;
        logic        hi;
        logic [7:0]  rd_addr;
        logic [7:0]  addr;
        logic [7:0]  word_lo;
        logic [15:0] rec_ptr;
        logic        rec;
        logic [1:0]  widx;
        logic        skip;
        logic        cfg_en;
        logic        host_iface;
        logic [1:0]  host_spd;
        logic [15:0] host_usb_lvl;
        logic [15:0] host_lan_ver;
        irq_vec_t    irq_stat;
        irq_vec_t    irq_en;
        logic [15:0] usb_opt;
        logic [1:0]  usb_spd;
        logic        usb_opt_valid;
        logic [15:0] usb_lvl;
        logic [15:0] lan_svid;
        logic [15:0] lan_sid;
        logic [15:0] lan_ver;
        logic        mac_dis;
        logic        lan_dis;
        logic        cfg_valid;
        id_sel_t     cfg_sel;
        logic [31:0] prdata;
        logic        pslverr;
    } loader_state_t;
endpackage : loader_pkg

// ### dv/loader_sva.sv
`timescale 1ns/1ps
`default_nettype none
module loader_sva
    import loader_pkg::*;
(
    // watched ports
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_o,
    input wire logic sda_o,
    input wire logic scl_oe,
    input wire logic mac_disable,
    input wire logic lan_disable,
    input wire logic [15:0] usb_opt_word,
    input wire logic cfg_wr_valid,
    input wire logic cfg_wr_ready,
    input wire id_sel_t cfg_wr_sel,
    input wire logic [15:0] cfg_wr_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_PREADY: assert property (psel |-> pready) else $error("pready low");
    AST_UNMAPPED: assert property (psel && penable && paddr > 8'h2c |-> pslverr) else $error("no slverr");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("stray slverr");
    AST_DRAIN: assert property (!scl_o && !sda_o) else $error("pin driven high");
    AST_SCL_LOW: assert property ($rose(scl_oe) |=> scl_oe [*8]) else $error("short low");
    AST_SPD_MASK: assert property (usb_opt_word[1:0] == 2'b00) else $error("speed bits");
    AST_CFG_HOLD: assert property (cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid && $stable(cfg_wr_data)
        && $stable(cfg_wr_sel)) else $error("cfg dropped");
    AST_CFG_FIRST: assert property ($rose(cfg_wr_valid) |-> cfg_wr_sel == SEL_SVID) else $error("order");
    AST_CFG_NEXT: assert property (cfg_wr_valid && cfg_wr_ready && cfg_wr_sel == SEL_SVID
        |=> cfg_wr_valid && cfg_wr_sel == SEL_SID) else $error("no sid");
    AST_CFG_EN: assert property (cfg_wr_valid |-> !mac_disable && !lan_disable) else $error("cfg");
endmodule : loader_sva
bind riser_usb_lan_config_loader loader_sva loader_sva_i (.ref_clk, .rst_n, .psel, .penable, .paddr,
    .pready, .pslverr, .scl_o, .sda_o, .scl_oe, .mac_disable, .lan_disable, .usb_opt_word,
    .cfg_wr_valid, .cfg_wr_ready, .cfg_wr_sel, .cfg_wr_data);
`default_nettype wire

// ### dv/eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "loader_params.svh"
module eeprom_model
(
    // bus wires and open-drain pulls
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    logic [7:0] mem [256];
    logic [7:0] sh, ptr;
    logic act, first, rdw, rdp;
    int bitc;
    bit slow = 1'b0;
    initial
    begin
        foreach (mem[k]) mem[k] = 8'h00;
        {scl_pull, sda_pull, act} = 3'b000;
    end
    always @(negedge sda)
    begin
        if (scl)
        begin
            {act, first, rdw, rdp} = 4'b1100;
            bitc = -1;
        end
    end
    always @(posedge sda) if (scl) act = 1'b0;
    // nack from the master ends a read
    always @(posedge scl)
    begin
        if (act && rdp && bitc == 8 && sda)
            act = 1'b0;
        if (act && !rdp && bitc < 8)
            sh = {sh[6:0], sda};
    end
    always @(negedge scl)
    begin
        if (act)
        begin
            bitc = (bitc == 8) ? 0 : bitc + 1;
            sda_pull = 1'b0;
            if (bitc == 0 && rdw)
                rdp = 1'b1;
            if (bitc == 8 && !rdp)
            begin
                sda_pull = !first || sh[7:1] == `EE_DEV_ADDR;
                if (first)
                    rdw = sh[0];
                else
                    ptr = sh;
                first = 1'b0;
            end
            if (rdp && bitc < 8)
                sda_pull = !mem[ptr][7-bitc];
            if (rdp && bitc == 8)
                ptr = ptr + 8'h01;
            scl_pull = slow;
            // when slow, hold scl 1000 ns past the master's own low phase, freed before the master's stretch check
            scl_pull <= #6000 1'b0;
        end
    end
endmodule : eeprom_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "loader_params.svh"
module testbench;
    import loader_pkg::*;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err_ack = 0, cfg_wr_ready = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, irq;
    logic mac_disable, lan_disable, usb_opt_valid, cfg_wr_valid;
    logic [15:0] usb_opt_word, cfg_wr_data;
    id_sel_t cfg_wr_sel;
    logic [1:0] cnt = 0;
    logic [16:0] cfg_log [$];
    int n_mismatch = 0, tests_run = 0;
    wire logic scl = !(scl_oe || m_scl);
    wire logic sda = !(sda_oe || m_sda);
    logic [15:0] image [14] = '{16'h1230, 16'h1636, 16'h183e, 16'h30c6, 16'h31a5, 16'h3205, 16'h3411,
        16'h3522, 16'h3601, 16'h3834, 16'h3912, 16'h3a78, 16'h3b56, 16'h3c03};
    riser_usb_lan_config_loader riser_usb_lan_config_loader_i (.ref_clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
        .sda_oe, .err_ack, .irq, .mac_disable, .lan_disable, .usb_opt_valid, .usb_opt_word,
        .cfg_wr_valid, .cfg_wr_sel, .cfg_wr_data, .cfg_wr_ready);
    eeprom_model eeprom_model_i (.scl, .sda, .scl_pull(m_scl), .sda_pull(m_sda));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cnt <= cnt + 2'd1;
    always @(posedge ref_clk) cfg_wr_ready <= (cnt == 2'd3);
    always @(posedge ref_clk) if (cfg_wr_valid === 1'b1 && cfg_wr_ready === 1'b1) cfg_log.push_back({cfg_wr_sel, cfg_wr_data});
    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask : apb
    task t_unmapped;
        apb(0, 8'h40, 0);
        check({err, rd}, 33'h100000000);
    endtask : t_unmapped
    task t_boot;
        logic [31:0] seen;
        int k;
        seen = 0;
        foreach (image[i]) eeprom_model_i.mem[image[i][15:8]] = image[i][7:0];
        apb(1, `REG_HOST, 3);
        apb(1, `REG_HOST_USB, 4);
        apb(1, `REG_HOST_LAN, 3);
        apb(1, `REG_IRQ_EN, 32'h1ff);
        apb(1, `REG_CTRL, 3);
        while (!seen[0])
        begin
            k = 0;
            while (irq !== 1'b1 && k < 3000000)
            begin
                @(posedge ref_clk);
                k++;
            end
            if (k >= 3000000)
                n_mismatch++;
            eeprom_model_i.slow = 1'b1;
            apb(0, `REG_IRQ_STAT, 0);
            seen = seen | rd;
            if (!rd[0])
            begin
                apb(1, `REG_IRQ_CLR, rd);
                check(irq, 0);
                apb(0, `REG_STATUS, 0);
                check(rd[7:4], M_ACK);
                err_ack <= 1;
                @(posedge ref_clk);
                err_ack <= 0;
            end
        end
        check(seen, 32'h00d);
        apb(1, `REG_IRQ_EN, 0);
        check(irq, 0);
        apb(1, `REG_IRQ_CLR, 32'h1ff);
        apb(1, `REG_IRQ_EN, 32'h1ff);
        check(irq, 0);
    endtask : t_boot
    task t_results;
        apb(0, `REG_USB_OPT, 0);
        check(rd, 32'h2a5c4);
        apb(0, `REG_USB_LVL, 0);
        check(rd, 32'h5);
        apb(0, `REG_LAN_IDS, 0);
        check(rd, 32'h56781234);
        apb(0, `REG_LAN_VER, 0);
        check(rd, 32'h3);
        check({usb_opt_valid, usb_opt_word, mac_disable, lan_disable}, {1'b1, 16'ha5c4, 2'b00});
        check(cfg_log.size(), 2);
        check({cfg_log[0], cfg_log[1]}, {17'h01234, 17'h15678});
    endtask : t_results
    task finish_test;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        t_unmapped();
        t_boot();
        t_results();
        finish_test();
    end
    initial
    begin
        #30000000;
        n_mismatch++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
